//--- rtl/wdt_sleep_pkg.sv
// constants, register map and carriers for the watchdog and sleep control block
// assumes a 100 MHz system clock and a 32-bit register bus
package wdt_sleep_pkg;
	// clock and timing
	localparam int CLK_MHZ = 100;
	localparam int WDT_PERIOD_MS = 18;
	localparam int WDT_PERIOD_CYC = WDT_PERIOD_MS * 1000 * CLK_MHZ;
	localparam int OST_TOSC = 1024;
	localparam int OST_CYC = OST_TOSC;
	localparam logic [10:0] OST_LAST = 11'(OST_CYC - 1);

	// register indices, byte address is four times the index
	localparam logic [15:0] IDX_OPTION = 16'h0081;
	localparam logic [15:0] IDX_CONFIG = 16'h2007;
	localparam logic [15:0] IDX_IRQCTL = 16'h000b;
	localparam logic [15:0] IDX_STATUS = 16'h0003;
	localparam logic [17:0] ADDR_OPTION = {IDX_OPTION, 2'b00};
	localparam logic [17:0] ADDR_CONFIG = {IDX_CONFIG, 2'b00};
	localparam logic [17:0] ADDR_IRQCTL = {IDX_IRQCTL, 2'b00};
	localparam logic [17:0] ADDR_STATUS = {IDX_STATUS, 2'b00};

	// reset values
	localparam logic [7:0] OPTION_RST = 8'hff;
	localparam logic [7:0] IRQCTL_RST = 8'h00;
	localparam logic [7:0] CONFIG_RST = 8'h00;

	// option field positions
	localparam int OPT_PSA = 3;
	localparam int OPT_PS_LO = 0;
	// config word field positions
	localparam int CFG_WATCHDOG_ENABLE_CFG = 2;
	localparam int CFG_FOSC2 = 4;
	localparam int CFG_FOSC1 = 1;
	localparam int CFG_FOSC0 = 0;
	// irq control and status field positions
	localparam int IRQ_GIE = 7;
	localparam int ST_TO = 4;
	localparam int ST_PD = 3;
	localparam int ST_ASLEEP = 0;

	// power state
	typedef enum logic [1:0] {RUN, ASLEEP, OSC_START} pstate_type;

	// instruction events from the processor core, one-cycle pulses
	typedef struct packed {
		logic clearWdt;
		logic sleep;
	} core_event_type;

	// indications back to the core
	typedef struct packed {
		logic deviceReset;
		logic resume;
		logic toVector;
		logic sleepNop;
	} core_answer_type;
endpackage

//--- rtl/wdt_sleep_ctrl.sv
// watchdog timer with sleep entry and wake-up control, APB register slave
// assumes clear_watchdog_instr/sleep pulses and interrupt flags come from logic on clk;
// the master-clear pin is asynchronous and is synchronised here
//
// Chosen here: the APB interface to the registers.
module wdt_sleep_ctrl #(
	parameter int WDT_BASE_CYC = wdt_sleep_pkg::WDT_PERIOD_CYC
) (
	// clock and power-on reset
	input wire logic clk,
	input wire logic resetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// core side
	input wire wdt_sleep_pkg::core_event_type coreEvent,
	output wdt_sleep_pkg::core_answer_type coreAnswer,
	// interrupt sources
	input wire logic [7:0] irqFlags,
	input wire logic [7:0] irqEnables,
	// device pins and strap
	input wire logic masterClearPinN,
	input wire logic [7:0] configWordIn,
	output logic mainOscEnable,
	output logic ioHold
);

	////////////////////////////////////////////////////////////////////////
	// declarations

	wdt_sleep_pkg::pstate_type state_r;
	logic [7:0] option_r;
	logic [7:0] irqCtl_r;
	logic [7:0] config_r;
	logic cfgLoaded_r;
	logic timeoutFlag_r;
	logic powerdownFlag_r;
	logic [31:0] baseCnt_r;
	logic [6:0] postCnt_r;
	logic [10:0] ostCnt_r;
	logic mclrMeta_r;
	logic mclrSync_r;
	logic [31:0] prdata_r;
	logic slvErr_r;
	wdt_sleep_pkg::core_answer_type answer_r;

	logic wdtOn;
	logic crystalMode;
	logic irqPending;
	logic sleepTake;
	logic sleepNop;
	logic wdtTick;
	logic [6:0] postLimit;
	logic timeout;
	logic wakeIrq;
	logic wakeWdt;
	logic wakeAny;
	logic wdtClear;
	logic mclrActive;
	logic devReset;
	logic setupPhase;
	logic accessWrite;
	logic [17:0] regAddr;

	////////////////////////////////////////////////////////////////////////
	// master-clear synchroniser; only the second stage is looked at

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mclrMeta_r <= 1'b0;
			mclrSync_r <= 1'b0;
		end else begin
			mclrMeta_r <= ~masterClearPinN;
			mclrSync_r <= mclrMeta_r;
		end
	end

	// pin is input only: a watchdog reset stays inside the device
	assign mclrActive = mclrSync_r;

	////////////////////////////////////////////////////////////////////////
	// configuration strap, caught after reset release

	// a strap cannot be loaded under async reset, so take it on the first edge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			config_r <= wdt_sleep_pkg::CONFIG_RST;
			cfgLoaded_r <= 1'b0;
		end else if (!cfgLoaded_r) begin
			config_r <= configWordIn;
			cfgLoaded_r <= 1'b1;
		end
	end

	// no register bit can turn the watchdog on once the fuse is clear
	assign wdtOn = config_r[wdt_sleep_pkg::CFG_WATCHDOG_ENABLE_CFG] & cfgLoaded_r;
	// oscillator modes with fosc2 low and not both low bits set need start-up
	assign crystalMode = ~config_r[wdt_sleep_pkg::CFG_FOSC2]
		& ~(config_r[wdt_sleep_pkg::CFG_FOSC1] & config_r[wdt_sleep_pkg::CFG_FOSC0]);

	////////////////////////////////////////////////////////////////////////
	// interrupt and sleep decisions

	// only individually enabled sources count, the global bit is ignored
	assign irqPending = |(irqFlags & irqEnables);
	assign sleepNop = coreEvent.sleep & ~irqCtl_r[wdt_sleep_pkg::IRQ_GIE]
		& irqPending;
	assign sleepTake = coreEvent.sleep & ~sleepNop & (state_r == wdt_sleep_pkg::RUN);
	assign wakeIrq = (state_r == wdt_sleep_pkg::ASLEEP) & irqPending;
	assign wakeWdt = (state_r == wdt_sleep_pkg::ASLEEP) & timeout;
	assign wakeAny = wakeIrq | wakeWdt;
	assign devReset = mclrActive | (timeout & (state_r != wdt_sleep_pkg::ASLEEP));

	////////////////////////////////////////////////////////////////////////
	// watchdog base counter, runs on the always-on tick even while asleep

	// the main oscillator enable does not gate this counter
	assign wdtTick = wdtOn & (baseCnt_r == 32'(WDT_BASE_CYC - 1));
	assign wdtClear = coreEvent.clearWdt | sleepTake | wakeAny | mclrActive;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			baseCnt_r <= 32'h0000_0000;
		end else if (wdtClear || !wdtOn || wdtTick) begin
			baseCnt_r <= 32'h0000_0000;
		end else begin
			baseCnt_r <= baseCnt_r + 32'h0000_0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// postscaler, ratio 2^ps when assigned to the watchdog

	always_comb begin
		if (option_r[wdt_sleep_pkg::OPT_PSA]) begin
			postLimit = 7'((8'h01 << option_r[wdt_sleep_pkg::OPT_PS_LO +: 3]) - 8'h01);
		end else begin
			postLimit = 7'h00;
		end
	end

	assign timeout = wdtTick & (postCnt_r == postLimit);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			postCnt_r <= 7'h00;
		end else if (wdtClear || timeout) begin
			postCnt_r <= 7'h00;
		end else if (wdtTick) begin
			postCnt_r <= postCnt_r + 7'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// power state machine

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= wdt_sleep_pkg::RUN;
		end else if (mclrActive) begin
			state_r <= wdt_sleep_pkg::RUN;
		end else begin
			case (state_r)
				wdt_sleep_pkg::RUN: begin
					if (sleepTake) begin
						state_r <= wdt_sleep_pkg::ASLEEP;
					end
				end
				wdt_sleep_pkg::ASLEEP: begin
					if (wakeAny && crystalMode) begin
						state_r <= wdt_sleep_pkg::OSC_START;
					end else if (wakeAny) begin
						state_r <= wdt_sleep_pkg::RUN;
					end
				end
				wdt_sleep_pkg::OSC_START: begin
					if (ostCnt_r == wdt_sleep_pkg::OST_LAST) begin
						state_r <= wdt_sleep_pkg::RUN;
					end
				end
				default: begin
					state_r <= wdt_sleep_pkg::RUN;
				end
			endcase
		end
	end

	// start-up wait counter, runs only in the start-up state
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ostCnt_r <= 11'h000;
		end else if (state_r == wdt_sleep_pkg::OSC_START) begin
			ostCnt_r <= ostCnt_r + 11'h001;
		end else begin
			ostCnt_r <= 11'h000;
		end
	end

	// oscillator stopped and pins frozen through sleep and start-up
	assign mainOscEnable = (state_r == wdt_sleep_pkg::RUN);
	assign ioHold = (state_r != wdt_sleep_pkg::RUN);

	////////////////////////////////////////////////////////////////////////
	// timeout and power-down flags

	// a time-out in the same cycle as sleep entry wins: the flag reads clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			timeoutFlag_r <= 1'b1;
			powerdownFlag_r <= 1'b1;
		end else begin
			if (timeout) begin
				timeoutFlag_r <= 1'b0;
			end else if (sleepTake) begin
				timeoutFlag_r <= 1'b1;
			end
			if (sleepTake) begin
				powerdownFlag_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// answers to the core

	// resume pulses when execution restarts after a watchdog or interrupt wake
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			answer_r <= '0;
		end else begin
			answer_r.deviceReset <= devReset;
			answer_r.sleepNop <= sleepNop;
			answer_r.resume <= ~mclrActive & (
				(wakeAny & ~crystalMode) |
				((state_r == wdt_sleep_pkg::OSC_START) &&
				(ostCnt_r == wdt_sleep_pkg::OST_LAST)));
			if (wakeAny) begin
				answer_r.toVector <= wakeIrq & irqCtl_r[wdt_sleep_pkg::IRQ_GIE];
			end else if (answer_r.resume) begin
				answer_r.toVector <= 1'b0;
			end
		end
	end

	assign coreAnswer = answer_r;

	////////////////////////////////////////////////////////////////////////
	// apb slave, zero wait states

	assign regAddr = paddr[17:0];
	assign setupPhase = psel & ~penable;
	assign accessWrite = psel & penable & pwrite & ~slvErr_r;

	// option and irq control; every device reset restores them
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			option_r <= wdt_sleep_pkg::OPTION_RST;
			irqCtl_r <= wdt_sleep_pkg::IRQCTL_RST;
		end else if (devReset) begin
			option_r <= wdt_sleep_pkg::OPTION_RST;
			irqCtl_r <= wdt_sleep_pkg::IRQCTL_RST;
		end else if (accessWrite && regAddr == wdt_sleep_pkg::ADDR_OPTION) begin
			option_r <= pwdata[7:0];
		end else if (accessWrite && regAddr == wdt_sleep_pkg::ADDR_IRQCTL) begin
			irqCtl_r <= pwdata[7:0];
		end
	end

	// read data and error captured in setup so it is stable in access
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prdata_r <= 32'h0000_0000;
			slvErr_r <= 1'b0;
		end else if (setupPhase) begin
			slvErr_r <= 1'b0;
			if (regAddr != paddr[17:0] || paddr[31:18] != 14'h0000) begin
				prdata_r <= 32'h0000_0000;
				slvErr_r <= 1'b1;
			end else if (regAddr == wdt_sleep_pkg::ADDR_OPTION) begin
				prdata_r <= {24'h000000, option_r};
			end else if (regAddr == wdt_sleep_pkg::ADDR_CONFIG) begin
				prdata_r <= {24'h000000, config_r};
				slvErr_r <= pwrite; // read-only word
			end else if (regAddr == wdt_sleep_pkg::ADDR_IRQCTL) begin
				prdata_r <= {24'h000000, irqCtl_r};
			end else if (regAddr == wdt_sleep_pkg::ADDR_STATUS) begin
				prdata_r <= {24'h000000, 3'b000, timeoutFlag_r, powerdownFlag_r,
					2'b00, state_r != wdt_sleep_pkg::RUN};
				slvErr_r <= pwrite;
			end else begin
				prdata_r <= 32'h0000_0000;
				slvErr_r <= 1'b1;
			end
		end
	end

	assign prdata = prdata_r;
	assign pready = 1'b1;
	assign pslverr = psel & penable & slvErr_r;

	////////////////////////////////////////////////////////////////////////
	// checks

	sequence sleepEntry_s;
		sleepTake ##1 (state_r == wdt_sleep_pkg::ASLEEP);
	endsequence

	sequence irqWake_s;
		(state_r == wdt_sleep_pkg::ASLEEP) && irqPending && !timeout && !mclrActive;
	endsequence

	wdt_disabled_a: assert property (@(posedge clk) disable iff (!resetn)
		!config_r[wdt_sleep_pkg::CFG_WATCHDOG_ENABLE_CFG] |-> !timeout)
		else $error("watchdog timed out while disabled");

	run_reset_a: assert property (@(posedge clk) disable iff (!resetn)
		timeout && state_r == wdt_sleep_pkg::RUN |=> coreAnswer.deviceReset)
		else $error("time-out while running gave no reset");

	sleep_wake_a: assert property (@(posedge clk) disable iff (!resetn)
		timeout && state_r == wdt_sleep_pkg::ASLEEP && !mclrActive
		|=> !coreAnswer.deviceReset && state_r != wdt_sleep_pkg::ASLEEP)
		else $error("time-out in sleep did not wake cleanly");

	timeout_flag_a: assert property (@(posedge clk) disable iff (!resetn)
		timeout |=> !timeoutFlag_r)
		else $error("timeout flag not cleared");

	sleep_flags_a: assert property (@(posedge clk) disable iff (!resetn)
		sleepEntry_s |-> !powerdownFlag_r && !mainOscEnable && ioHold
		&& baseCnt_r == 32'h0000_0000)
		else $error("sleep entry effects missing");

	clear_instr_a: assert property (@(posedge clk) disable iff (!resetn)
		coreEvent.clearWdt && !timeout |=> baseCnt_r == 32'h0000_0000
		&& postCnt_r == 7'h00)
		else $error("clear instruction left watchdog counting");

	sleep_nop_a: assert property (@(posedge clk) disable iff (!resetn)
		sleepNop |=> state_r == wdt_sleep_pkg::RUN && coreAnswer.sleepNop)
		else $error("sleep taken with pending disabled interrupt");

	irq_vector_a: assert property (@(posedge clk) disable iff (!resetn)
		irqWake_s |=> coreAnswer.toVector == $past(irqCtl_r[wdt_sleep_pkg::IRQ_GIE])
		&& baseCnt_r == 32'h0000_0000)
		else $error("wake vector choice or counter clear wrong");

	ost_wait_a: assert property (@(posedge clk) disable iff (!resetn)
		wakeAny && crystalMode && !mclrActive |=> !coreAnswer.resume [*8])
		else $error("resumed before oscillator start-up");

	gie_reset_a: assert property (@(posedge clk) disable iff (!resetn)
		devReset |=> !irqCtl_r[wdt_sleep_pkg::IRQ_GIE])
		else $error("global enable survived a reset");

endmodule

//--- verif/core_model.sv
// partner model of the processor core that issues clear and sleep instructions
// assumes the bench calls issue() from one process only, after a rising edge
module core_model (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// instruction events out, answers back
	output wdt_sleep_pkg::core_event_type coreEvent,
	input wire wdt_sleep_pkg::core_answer_type coreAnswer
);
	timeunit 1ns;
	timeprecision 1ps;
	int resumeCount = 0;
	int vectorCount = 0;

	initial coreEvent = '0;

	////////////////////////////////////////////////////////////////////////////////
	// one instruction: a single-cycle pulse, since the block samples every edge
	task automatic issue(input logic clr, input logic slp);
		@(posedge clk);
		coreEvent <= '{clearWdt: clr, sleep: slp};
		@(posedge clk);
		coreEvent <= '0;
	endtask

	// prefetched instruction runs on resume; the vector follows only when asked
	always @(posedge clk) begin
		if (resetn && coreAnswer.resume === 1'b1) begin
			resumeCount <= resumeCount + 1;
			if (coreAnswer.toVector === 1'b1) vectorCount <= vectorCount + 1;
		end
	end
endmodule

//--- verif/test_watchdog_sleep_wake_ctrl.sv
// self-checking bench for the watchdog, sleep entry and wake-up block
// assumes core_model.sv as the core partner and a 100 MHz clock
module test_watchdog_sleep_wake_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	// short watchdog base so time-outs fit the run
	localparam int BASE = 20;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready, pslverr, mainOscEnable, ioHold;
	logic [7:0] irqFlags = '0;
	logic [7:0] irqEnables = '0;
	logic masterClearPinN = 1'b1;
	logic [7:0] configWordIn = 8'h14;
	wdt_sleep_pkg::core_event_type coreEvent;
	wdt_sleep_pkg::core_answer_type coreAnswer;
	logic [31:0] readQ[$];
	logic [31:0] rs = 32'h0000c572;
	logic [31:0] rnd;
	int bad_count = 0;
	int compares = 0;
	int resetSeen = 0;
	int n;
	int b;

	always #5 clk = ~clk;

	wdt_sleep_ctrl #(.WDT_BASE_CYC(BASE)) i_dut (.clk(clk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .coreEvent(coreEvent), .coreAnswer(coreAnswer),
		.irqFlags(irqFlags), .irqEnables(irqEnables), .masterClearPinN(masterClearPinN),
		.configWordIn(configWordIn), .mainOscEnable(mainOscEnable), .ioHold(ioHold));
	core_model i_core (.clk(clk), .resetn(resetn), .coreEvent(coreEvent),
		.coreAnswer(coreAnswer));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// clock spans get slack for sync and register stages, not for a wrong ratio
	task automatic span(input string name, input int cnt, input int nom);
		check(name, 32'(cnt >= nom - 2 && cnt <= nom + 6), 32'h1);
	endtask

	function automatic logic [31:0] xs();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction

	// read expectations go to the queue; the monitor pairs them with prdata
	task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d,
		input logic err);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= 32'(a);
		pwdata <= d;
		if (!wr && !err) readQ.push_back(d);
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		check("pslverr", 32'(pslverr), 32'(err));
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic do_reset(input logic [7:0] cfg);
		@(posedge clk);
		resetn <= 1'b0;
		configWordIn <= cfg;
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
	endtask

	function automatic logic pick(input int sel);
		case (sel)
			0: return coreAnswer.deviceReset;
			1: return coreAnswer.resume;
			default: return coreAnswer.sleepNop;
		endcase
	endfunction

	// bounded wait; cnt ends at limit + 1 when the answer never came
	task automatic wait_for(input int sel, input int limit, output int cnt);
		cnt = 0;
		do begin
			@(negedge clk);
			cnt++;
		end while (pick(sel) !== 1'b1 && cnt <= limit);
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// read monitor; refused reads queue nothing
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && pslverr !== 1'b1 && readQ.size() > 0)
			check("prdata", prdata, readQ.pop_front());
	end

	always @(negedge clk) begin
		if (coreAnswer.deviceReset === 1'b1) resetSeen++;
	end

	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		end_of_test();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		do_reset(8'h14);
		apb(0, wdt_sleep_pkg::ADDR_OPTION, 32'h000000ff, 0);
		apb(0, wdt_sleep_pkg::ADDR_IRQCTL, 32'h00000000, 0);
		apb(0, wdt_sleep_pkg::ADDR_STATUS, 32'h00000018, 0);
		apb(1, wdt_sleep_pkg::ADDR_CONFIG, 32'h00000000, 1);
		apb(1, wdt_sleep_pkg::ADDR_STATUS, 32'h00000000, 1);
		apb(0, 18'h00010, 32'h00000000, 1);
		apb(0, wdt_sleep_pkg::ADDR_CONFIG, 32'h00000014, 0);
		// every postscaler ratio, then none assigned
		for (int k = 0; k < 8; k++) begin
			apb(1, wdt_sleep_pkg::ADDR_OPTION, 32'(8'h08 | k), 0);
			i_core.issue(1'b1, 1'b0);
			wait_for(0, 2600, n);
			span("scaled time-out", n, BASE << k);
		end
		apb(1, wdt_sleep_pkg::ADDR_OPTION, 32'h00000000, 0);
		i_core.issue(1'b1, 1'b0);
		wait_for(0, 100, n);
		span("base time-out", n, BASE);
		apb(0, wdt_sleep_pkg::ADDR_STATUS, 32'h00000008, 0);
		// the time-out restored the option word: go back to ratio one for the kicks
		apb(1, wdt_sleep_pkg::ADDR_OPTION, 32'h00000000, 0);
		b = resetSeen;
		repeat (8) begin
			i_core.issue(1'b1, 1'b0);
			repeat (14) @(posedge clk);
		end
		check("kicked resets", 32'(resetSeen - b), 32'h0);
		// sleep, then watchdog wake without reset
		i_core.issue(1'b0, 1'b1);
		@(negedge clk);
		check("osc in sleep", 32'(mainOscEnable), 32'h0);
		check("pins held", 32'(ioHold), 32'h1);
		b = resetSeen;
		wait_for(1, 40, n);
		span("watchdog wake", n, BASE);
		check("wake no reset", 32'(resetSeen - b), 32'h0);
		check("wake vector", 32'(coreAnswer.toVector), 32'h0);
		wait_for(0, 100, n);
		span("cleared on wake", n, BASE);
		apb(0, wdt_sleep_pkg::ADDR_STATUS, 32'h00000000, 0);
		// interrupt wake with global enable set, then clear
		apb(1, wdt_sleep_pkg::ADDR_OPTION, 32'h0000000f, 0);
		for (int g = 1; g >= 0; g--) begin
			@(posedge clk);
			rnd = xs();
			b = int'(rnd % 32'h8);
			irqFlags <= '0;
			irqEnables <= 8'(8'h01 << b);
			apb(1, wdt_sleep_pkg::ADDR_IRQCTL, 32'(g) << 7, 0);
			i_core.issue(1'b0, 1'b1);
			irqFlags <= rnd[7:0] & ~irqEnables;
			apb(0, wdt_sleep_pkg::ADDR_STATUS, 32'h00000011, 0);
			wait_for(1, 10, n);
			check("masked wake", 32'(n), 32'h0000000b);
			@(posedge clk);
			irqFlags <= irqFlags | irqEnables;
			wait_for(1, 5, n);
			check("irq wake", 32'(n <= 5), 32'h1);
			check("vector", 32'(coreAnswer.toVector), 32'(g));
		end
		check("vectors taken", 32'(i_core.vectorCount), 32'h1);
		// global off with a pending enabled source: sleep is refused
		i_core.issue(1'b0, 1'b1);
		wait_for(2, 3, n);
		check("nop sleep", 32'(n <= 3), 32'h1);
		check("osc kept", 32'(mainOscEnable), 32'h1);
		// master clear while asleep resets and does not resume
		apb(1, wdt_sleep_pkg::ADDR_OPTION, 32'h00000000, 0);
		irqFlags <= '0;
		b = i_core.resumeCount;
		i_core.issue(1'b0, 1'b1);
		masterClearPinN <= 1'b0;
		wait_for(0, 6, n);
		check("pin reset", 32'(n <= 6), 32'h1);
		repeat (4) @(posedge clk);
		masterClearPinN <= 1'b1;
		repeat (4) @(posedge clk);
		check("pin no resume", 32'(i_core.resumeCount - b), 32'h0);
		apb(0, wdt_sleep_pkg::ADDR_OPTION, 32'h000000ff, 0);
		apb(0, wdt_sleep_pkg::ADDR_IRQCTL, 32'h00000000, 0);
		// crystal mode waits for oscillator start-up
		do_reset(8'h04);
		irqEnables <= 8'h01;
		irqFlags <= '0;
		i_core.issue(1'b0, 1'b1);
		repeat (3) @(posedge clk);
		irqFlags <= 8'h01;
		repeat (10) @(negedge clk);
		check("osc in start-up", 32'(mainOscEnable), 32'h0);
		check("pins in start-up", 32'(ioHold), 32'h1);
		wait_for(1, 1100, n);
		span("start-up wait", n, wdt_sleep_pkg::OST_CYC - 10);
		// strap bit clear keeps the watchdog off
		do_reset(8'h10);
		apb(1, wdt_sleep_pkg::ADDR_OPTION, 32'h00000000, 0);
		b = resetSeen;
		repeat (200) @(posedge clk);
		check("watchdog off", 32'(resetSeen - b), 32'h0);
		end_of_test();
	end
endmodule
